// ---- lane_config_i2c_slave_tb.sv ----
/*
  Self-checking bench of the configuration slave: writes, reads, wrong
  addresses and all pin addresses through the I2C master model.
  Assumes the master model file is compiled before this one.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module lane_config_i2c_slave_tb;
  logic clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0, strap, clr_seen, scl, sda_low, sda_wire, ack;
  logic sda_out, sda_oe, ce = 1'b1;
  logic [2:0] apins;
  logic [3:0] loop_n;
  logic [1:0] deemph;
  logic [7:0] valid_flag, load_flag, in_off, out_off, squelch, det_start, det_en, pwr_n, eq_a, eq_b;
  logic [7:0] thresh, det_seen, rd, expv;
  logic [7:0] bank [12];
  logic [7:0] wq [$];
  int num_errors = 0;
  int n_checks = 0;
  // ----------------------------------------
  // Clocks, wire and pulse catcher
  // ----------------------------------------
  always #50 clk = ~clk;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  assign sda_wire = (sda_low || sda_oe) ? 1'b0 : 1'b1;
  // Start pulses last one cycle, so gather them
  always @(posedge clk) det_seen <= clr_seen ? 8'h00 : (det_seen | det_start);
  lcis_cfg_slave lcis_cfg_slave_inst (.CLK(clk), .RESET_N(reset_n), .CE(ce), .LINK_CLK(link_clk),
    .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_PIN_HIGH(apins[2]),
    .ADDR_PIN_MID(apins[1]), .ADDR_PIN_LOW(apins[0]), .LOOP_STRAP_N(strap), .INPUT_VALID_FLAG(valid_flag),
    .LOAD_FOUND_FLAG(load_flag), .LANE_PAIR_LOOP_N(loop_n), .GROUP_DEEMPH_SELECT(deemph),
    .INPUT_OFF_BIT(in_off), .OUTPUT_OFF_BIT(out_off), .CHANNEL_SQUELCH(squelch), .DETECT_START(det_start),
    .DETECT_ENABLE(det_en), .CHANNEL_POWER_N(pwr_n), .EQ_A_CTRL(eq_a), .EQ_B_CTRL(eq_b),
    .IDLE_THRESH(thresh));
  lcis_i2c_master lcis_i2c_master_inst (.clk(clk), .sda_in(sda_wire), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [7:0] dev_addr(input logic [2:0] p, input logic rw);
    return {2'h3, p[2], 2'h0, p[1], p[0], rw};
  endfunction
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check_ports();
    `CHK(loop_n, bank[2][7:4])
    `CHK(deemph, bank[2][3:2])
    `CHK(in_off, bank[3])
    `CHK(out_off, bank[4])
    `CHK({pwr_n, det_en, eq_a, eq_b, thresh}, {bank[6], bank[7], bank[8], bank[9], bank[11]})
  endtask
  // Reset of design and bank model together; bytes 0 and 1 stay live inputs
  task automatic reset_cycle();
    reset_n = 1'b0;
    bank = '{8'h00, 8'h00, strap ? 8'hf0 : 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hef};
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (40) @(negedge clk);
    check_ports();
  endtask
  // Filler byte first, then the queued bytes from offset zero
  task automatic wr_frame(input logic [2:0] p, input logic nack);
    lcis_i2c_master_inst.start();
    lcis_i2c_master_inst.wr_byte(dev_addr(p, 1'b0), ack);
    `CHK(ack, nack)
    if (!nack) begin
      lcis_i2c_master_inst.wr_byte(8'($urandom), ack);
      `CHK(ack, 1'b0)
      foreach (wq[i]) begin
        lcis_i2c_master_inst.wr_byte(wq[i], ack);
        `CHK(ack, 1'b0)
        if (i > 1 && i < 12) bank[i] = (i == 2) ? (wq[i] & 8'hfc) : wq[i];
      end
    end
    lcis_i2c_master_inst.stop();
    repeat (10) @(negedge clk);
  endtask
  task automatic rd_frame(input logic [2:0] p, input int n);
    lcis_i2c_master_inst.start();
    lcis_i2c_master_inst.wr_byte(dev_addr(p, 1'b1), ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < n; i++) begin
      lcis_i2c_master_inst.rd_byte(i == n - 1, rd);
      expv = (i == 0) ? valid_flag : (i == 1) ? load_flag : (i < 12) ? bank[i] : 8'h00;
      `CHK(rd, expv)
    end
    lcis_i2c_master_inst.stop();
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    void'($urandom(57));
    strap = 1'($urandom);
    apins = 3'($urandom);
    valid_flag = 8'($urandom);
    load_flag = 8'($urandom);
    clr_seen = 1'b1;
    reset_cycle();
    `CHK({squelch, sda_out}, {~valid_flag, 1'b0})
    for (int i = 0; i < 13; i++) wq.push_back(i == 5 ? 8'h00 : (i == 6 || i == 7) ? 8'hff : 8'($urandom));
    wr_frame(apins, 1'b0);
    check_ports();
    rd_frame(apins, 18);
    // Short rewrite must land at offset zero again; restart bits rise
    clr_seen = 1'b0;
    wq = {};
    for (int i = 0; i < 8; i++) wq.push_back(i >= 5 ? 8'hff : 8'($urandom));
    wr_frame(apins, 1'b0);
    check_ports();
    `CHK(det_seen, 8'hff)
    rd_frame(apins, 6);
    // Mid-run reset with the strap flipped; writable bytes must return
    strap = ~strap;
    reset_cycle();
    // Frozen core keeps the old squelch, then follows once enabled
    ce = 1'b0;
    valid_flag = ~valid_flag;
    repeat (10) @(negedge clk);
    `CHK(squelch, valid_flag)
    ce = 1'b1;
    repeat (5) @(negedge clk);
    `CHK(squelch, ~valid_flag)
    wr_frame(apins ^ 3'h4, 1'b1);
    check_ports();
    for (int k = 0; k < 8; k++) begin
      apins = 3'(k);
      repeat (20) @(negedge clk);
      rd_frame(3'(k), 2);
    end
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule

// ---- lcis_cfg_slave.sv ----
/*
  I2C configuration slave with its twelve-byte register bank.
  The bus side runs on LINK_CLK, an oversampling clock of its own; the
  bank and all lane controls run on CLK. SCL and SDA are open-drain pins
  resolved outside; this block never drives SCL.
*/
`timescale 1ns/1ps
module lcis_cfg_slave #(
  parameter logic [7:0] RST_RESTART = lcis_pkg::RST_RESTART,
  parameter logic [7:0] RST_PWR = lcis_pkg::RST_PWR,
  parameter logic [7:0] RST_LOAD_DETECT_ENABLE = lcis_pkg::RST_LOAD_DETECT_ENABLE,
  parameter logic [7:0] RST_EQ_A = lcis_pkg::RST_EQ,
  parameter logic [7:0] RST_EQ_B = lcis_pkg::RST_EQ,
  parameter logic [1:0] RST_DEEMPH = lcis_pkg::RST_DEEMPH
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic ADDR_PIN_HIGH,
  input wire logic ADDR_PIN_MID,
  input wire logic ADDR_PIN_LOW,
  input wire logic LOOP_STRAP_N,
  input wire logic [7:0] INPUT_VALID_FLAG,
  input wire logic [7:0] LOAD_FOUND_FLAG,
  output logic [3:0] LANE_PAIR_LOOP_N,
  output logic [1:0] GROUP_DEEMPH_SELECT,
  output logic [7:0] INPUT_OFF_BIT,
  output logic [7:0] OUTPUT_OFF_BIT,
  output logic [7:0] CHANNEL_SQUELCH,
  output logic [7:0] DETECT_START,
  output logic [7:0] DETECT_ENABLE,
  output logic [7:0] CHANNEL_POWER_N,
  output logic [7:0] EQ_A_CTRL,
  output logic [7:0] EQ_B_CTRL,
  output logic [7:0] IDLE_THRESH
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACKA, S_WDATA, S_WACK, S_RDATA, S_RACK} lcis_state_e;

  // ----------------------------------------
  // Link domain: pins
  // ----------------------------------------
  logic lrst_n;
  logic scl_f;
  logic sda_f;
  logic scl_q_r;
  logic sda_q_r;
  logic [2:0] apin_s;

  lcis_sync2 #(.W(1)) u_lrst (.clk(LINK_CLK), .en(1'b1), .d(RESET_N), .q(lrst_n));
  lcis_sync2 #(.W(3)) u_apin (
    .clk(LINK_CLK),
    .en(1'b1),
    .d({ADDR_PIN_HIGH, ADDR_PIN_MID, ADDR_PIN_LOW}),
    .q(apin_s)
  );
  lcis_pin_filt #(.LEN(lcis_pkg::FILT_CYC)) u_scl (.clk(LINK_CLK), .rst_n(lrst_n), .d(SCL_IN), .q(scl_f));
  lcis_pin_filt #(.LEN(lcis_pkg::FILT_CYC)) u_sda (.clk(LINK_CLK), .rst_n(lrst_n), .d(SDA_IN), .q(sda_f));

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // ----------------------------------------
  // Link domain: bus events
  // ----------------------------------------
  lcis_state_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [3:0] ptr_r;
  logic rw_r;
  logic dummy_r;
  logic sda_oe_r;
  logic req_tgl_r;
  logic req_we_r;
  logic [3:0] req_addr_r;
  logic [7:0] req_data_r;
  logic [7:0] rd_hold_r;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_match;
  logic byte_end;
  logic addr_end;
  logic wbyte_end;
  logic rbyte_end;
  logic acka_end;

  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign start_det = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_det = scl_f & scl_q_r & ~sda_q_r & sda_f;
  // Three strapped bits give eight bus addresses
  assign addr_match = shift_r[7:1] == {lcis_pkg::ADDR_TOP, apin_s[2], lcis_pkg::ADDR_GAP, apin_s[1:0]};
  assign byte_end = scl_fall && (cnt_r == lcis_pkg::BIT_LAST);
  assign addr_end = (st_r == S_ADDR) && byte_end;
  assign wbyte_end = (st_r == S_WDATA) && byte_end;
  assign rbyte_end = (st_r == S_RDATA) && byte_end;
  assign acka_end = (st_r == S_ACKA) && scl_fall;

  // ----------------------------------------
  // Link domain: byte engine
  // ----------------------------------------
  // Only SDA is ever driven, so the master is never stalled
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      st_r <= S_ADDR;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      st_r <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        S_IDLE: begin
        end
        S_ADDR, S_WDATA: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f};
            cnt_r <= cnt_r + 4'h1;
          end else if (addr_end) begin
            rw_r <= shift_r[0];
            sda_oe_r <= addr_match;
            st_r <= addr_match ? S_ACKA : S_IDLE;
          end else if (wbyte_end) begin
            sda_oe_r <= 1'b1;
            st_r <= S_WACK;
          end
        end
        S_ACKA: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            shift_r <= rd_hold_r;
            sda_oe_r <= rw_r & ~rd_hold_r[7];
            st_r <= rw_r ? S_RDATA : S_WDATA;
          end
        end
        S_WACK: begin
          // Acknowledge held until the ack clock falls
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            cnt_r <= 4'h0;
            st_r <= S_WDATA;
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (rbyte_end) begin
            sda_oe_r <= 1'b0;
            st_r <= S_RACK;
          end else if (scl_fall && cnt_r != 4'h0) begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_r <= ~shift_r[6];
          end
        end
        S_RACK: begin
          // A missing acknowledge ends the read; wait for stop
          if (scl_rise && sda_f) begin
            st_r <= S_IDLE;
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            shift_r <= rd_hold_r;
            sda_oe_r <= ~rd_hold_r[7];
            st_r <= S_RDATA;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Link domain: byte pointer
  // ----------------------------------------
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      ptr_r <= 4'h0;
      dummy_r <= 1'b0;
    end else if (start_det || stop_det) begin
      ptr_r <= 4'h0;
      dummy_r <= 1'b0;
    end else if (acka_end) begin
      dummy_r <= ~rw_r;
    end else if (wbyte_end) begin
      dummy_r <= 1'b0;
      if (!dummy_r && ptr_r != lcis_pkg::PTR_MAX) begin
        ptr_r <= ptr_r + 4'h1;
      end
    end else if (rbyte_end && ptr_r != lcis_pkg::PTR_MAX) begin
      ptr_r <= ptr_r + 4'h1;
    end
  end

  // ----------------------------------------
  // Link domain: requests to the bank
  // ----------------------------------------
  // Fields stay put until the next toggle, far longer than the crossing
  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      req_tgl_r <= 1'b0;
      req_we_r <= 1'b0;
      req_addr_r <= 4'h0;
      req_data_r <= 8'h00;
    end else if (addr_end && addr_match && shift_r[0]) begin
      req_tgl_r <= ~req_tgl_r;
      req_we_r <= 1'b0;
      req_addr_r <= lcis_pkg::OFS_LEVEL;
    end else if (rbyte_end) begin
      req_tgl_r <= ~req_tgl_r;
      req_we_r <= 1'b0;
      // Saturated pointer must not wrap back onto byte zero
      req_addr_r <= (ptr_r == lcis_pkg::PTR_MAX) ? ptr_r : ptr_r + 4'h1;
    end else if (wbyte_end && !dummy_r && ptr_r < lcis_pkg::NUM_BYTES) begin
      req_tgl_r <= ~req_tgl_r;
      req_we_r <= 1'b1;
      req_addr_r <= ptr_r;
      req_data_r <= shift_r;
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (!lrst_n) begin
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      SDA_OUT <= 1'b0;
      SDA_OE <= sda_oe_r;
    end
  end

  // ----------------------------------------
  // Core domain: crossing and status
  // ----------------------------------------
  logic req_s;
  logic req_q_r;
  logic req_seen;
  logic strap_s;
  logic strap_pend_r;
  logic [7:0] valid_s;
  logic [7:0] load_s;
  logic [7:0] cfg_r [2:11];
  logic [7:0] restart_q_r;
  logic [7:0] rd_mux;

  lcis_sync2 #(.W(1)) u_req (.clk(CLK), .en(CE), .d(req_tgl_r), .q(req_s));
  lcis_sync2 #(.W(1)) u_strap (.clk(CLK), .en(CE), .d(LOOP_STRAP_N), .q(strap_s));
  lcis_sync2 #(.W(8)) u_valid (.clk(CLK), .en(CE), .d(INPUT_VALID_FLAG), .q(valid_s));
  lcis_sync2 #(.W(8)) u_load (.clk(CLK), .en(CE), .d(LOAD_FOUND_FLAG), .q(load_s));

  assign req_seen = req_s ^ req_q_r;

  always_comb begin
    rd_mux = 8'h00;
    if (req_addr_r == lcis_pkg::OFS_LEVEL) begin
      rd_mux = valid_s;
    end else if (req_addr_r == lcis_pkg::OFS_LOAD) begin
      rd_mux = load_s;
    end else if (req_addr_r < lcis_pkg::NUM_BYTES) begin
      rd_mux = cfg_r[req_addr_r];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      req_q_r <= 1'b0;
      rd_hold_r <= 8'h00;
    end else if (CE) begin
      req_q_r <= req_s;
      if (req_seen && !req_we_r) begin
        rd_hold_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Core domain: register bank
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      strap_pend_r <= 1'b1;
      cfg_r[lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL] <= {4'hf, RST_DEEMPH, 2'h0};
      cfg_r[lcis_pkg::OFS_IN_OFF] <= lcis_pkg::RST_ZERO;
      cfg_r[lcis_pkg::OFS_OUT_OFF] <= lcis_pkg::RST_ZERO;
      cfg_r[lcis_pkg::OFS_RESTART] <= RST_RESTART;
      cfg_r[lcis_pkg::OFS_PWR] <= RST_PWR;
      cfg_r[lcis_pkg::OFS_LOAD_DETECT_ENABLE] <= RST_LOAD_DETECT_ENABLE;
      cfg_r[lcis_pkg::OFS_EQ_A] <= RST_EQ_A;
      cfg_r[lcis_pkg::OFS_EQ_B] <= RST_EQ_B;
      cfg_r[lcis_pkg::OFS_RSVD] <= lcis_pkg::RST_ZERO;
      cfg_r[lcis_pkg::OFS_THRESH] <= lcis_pkg::RST_THRESH;
    end else if (CE) begin
      // Strap is caught once, on the first enabled edge after release
      if (strap_pend_r) begin
        strap_pend_r <= 1'b0;
        cfg_r[lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL][lcis_pkg::LOOP_MSB:lcis_pkg::LOOP_LSB] <= {4{strap_s}};
      end else if (req_seen && req_we_r) begin
        if (req_addr_r == lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL) begin
          cfg_r[lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL] <= req_data_r & lcis_pkg::LOOPBACK_EMPHASIS_CTRL_WMASK;
        end else if (req_addr_r > lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL && req_addr_r < lcis_pkg::NUM_BYTES) begin
          cfg_r[req_addr_r] <= req_data_r;
        end
      end
    end
  end

  // ----------------------------------------
  // Core domain: lane controls
  // ----------------------------------------
  logic [7:0] det_start_nxt;

  // One driver for the pulse register, so per-bit logic stays combinational
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_det
      assign det_start_nxt[gi] = cfg_r[lcis_pkg::OFS_RESTART][gi] & ~restart_q_r[gi]
                                 & cfg_r[lcis_pkg::OFS_PWR][gi] & cfg_r[lcis_pkg::OFS_LOAD_DETECT_ENABLE][gi];
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CHANNEL_SQUELCH <= 8'hff;
      restart_q_r <= RST_RESTART;
      DETECT_START <= 8'h00;
    end else if (CE) begin
      CHANNEL_SQUELCH <= ~valid_s;
      restart_q_r <= cfg_r[lcis_pkg::OFS_RESTART];
      DETECT_START <= det_start_nxt;
    end
  end

  assign LANE_PAIR_LOOP_N = cfg_r[lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL][lcis_pkg::LOOP_MSB:lcis_pkg::LOOP_LSB];
  assign GROUP_DEEMPH_SELECT = {cfg_r[lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL][lcis_pkg::DE_A_BIT],
                                cfg_r[lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL][lcis_pkg::DE_B_BIT]};
  assign INPUT_OFF_BIT = cfg_r[lcis_pkg::OFS_IN_OFF];
  assign OUTPUT_OFF_BIT = cfg_r[lcis_pkg::OFS_OUT_OFF];
  assign DETECT_ENABLE = cfg_r[lcis_pkg::OFS_LOAD_DETECT_ENABLE];
  assign CHANNEL_POWER_N = cfg_r[lcis_pkg::OFS_PWR];
  assign EQ_A_CTRL = cfg_r[lcis_pkg::OFS_EQ_A];
  assign EQ_B_CTRL = cfg_r[lcis_pkg::OFS_EQ_B];
  assign IDLE_THRESH = cfg_r[lcis_pkg::OFS_THRESH];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ack_on_match: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    addr_end && addr_match && !start_det && !stop_det |=> sda_oe_r && st_r == S_ACKA ##1 SDA_OE)
    else $error("address match not acknowledged");
  a_passive_miss: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    addr_end && !addr_match && !start_det && !stop_det |=> !sda_oe_r && st_r == S_IDLE)
    else $error("mismatched address not ignored");
  a_stop_ptr_zero: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    stop_det |=> ptr_r == 4'h0)
    else $error("pointer not cleared by stop");
  a_dummy_skip: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    wbyte_end && dummy_r && !start_det && !stop_det |=> $stable(req_tgl_r) && ptr_r == 4'h0)
    else $error("filler byte was stored");
  a_ack_held: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
    st_r == S_WACK && scl_f && !stop_det && !start_det |-> SDA_OE)
    else $error("acknowledge released while clock high");
  a_write_lands: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req_seen && req_we_r && !strap_pend_r && req_addr_r == lcis_pkg::OFS_IN_OFF
    |=> INPUT_OFF_BIT == $past(req_data_r))
    else $error("write data not stored");
  a_rsvd_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req_seen && !req_we_r && req_addr_r == lcis_pkg::OFS_LOOPBACK_EMPHASIS_CTRL |=> rd_hold_r[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  a_high_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req_seen && !req_we_r && req_addr_r >= lcis_pkg::NUM_BYTES |=> rd_hold_r == 8'h00)
    else $error("byte past bank read nonzero");
  a_restart_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && cfg_r[lcis_pkg::OFS_RESTART][0] && !restart_q_r[0] && cfg_r[lcis_pkg::OFS_PWR][0]
    && cfg_r[lcis_pkg::OFS_LOAD_DETECT_ENABLE][0] |=> DETECT_START[0] ##1 !DETECT_START[0] || !CE)
    else $error("restart edge gave no single pulse");
  a_reset_off: assert property (@(posedge CLK)
    !RESET_N |=> INPUT_OFF_BIT == 8'h00 && OUTPUT_OFF_BIT == 8'h00)
    else $error("disable bytes not cleared by reset");
  c_write_byte: cover property (@(posedge LINK_CLK) disable iff (!lrst_n) wbyte_end && !dummy_r);
  c_read_byte: cover property (@(posedge LINK_CLK) disable iff (!lrst_n) rbyte_end);
  c_addr_miss: cover property (@(posedge LINK_CLK) disable iff (!lrst_n) addr_end && !addr_match);
  c_detect: cover property (@(posedge CLK) disable iff (!RESET_N) DETECT_START != 8'h00);
endmodule

// ---- lcis_i2c_master.sv ----
/*
  Behavioural I2C bus master for the configuration slave bench.
  Assumes a pull-up on SDA resolved by the bench; times steps on the core
  clock's falling edge, a quarter bit being 25 cycles of 100 ns.
*/
`timescale 1ns/1ps
module lcis_i2c_master (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  localparam int QTR = 25;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold();
    repeat (QTR) @(negedge clk);
  endtask
  // ----------------------------------------
  // Bus conditions and bits
  // ----------------------------------------
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
    hold();
  endtask
  // Sample mid-high, long after the slave settled SDA
  task automatic clock_bit(input logic b, output logic s);
    sda_low = ~b;
    hold();
    scl = 1'b1;
    hold();
    s = sda_in;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, ack);
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      d[i] = s;
    end
    clock_bit(last, s);
  endtask
endmodule

// ---- lcis_pin_filt.sv ----
/*
  Synchronises one bus pin and suppresses spikes shorter than LEN cycles.
  Assumes an active-low synchronous reset in the same clock domain; the
  filtered level resets high, the idle level of an I2C line.
*/
`timescale 1ns/1ps
module lcis_pin_filt #(
  parameter int LEN = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic d_s;
  logic [3:0] cnt_r;

  lcis_sync2 #(.W(1)) u_sync (
    .clk(clk),
    .en(1'b1),
    .d(d),
    .q(d_s)
  );

  // New level must persist LEN samples before it is believed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= 1'b1;
      cnt_r <= 4'h0;
    end else if (d_s == q) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == 4'(LEN - 1)) begin
      q <= d_s;
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

// ---- lcis_pkg.sv ----
/*
  Shared constants of the lane configuration I2C slave: byte offsets,
  address layout, reset values and glitch filter timing.
  Assumes nothing; it is compiled first.
*/
package lcis_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int PTR_W = 4;
  localparam logic [3:0] NUM_BYTES = 4'hc;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] PTR_MAX = 4'hf;
  // ----------------------------------------
  // Byte offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_LEVEL = 4'h0;
  localparam logic [3:0] OFS_LOAD = 4'h1;
  localparam logic [3:0] OFS_LOOPBACK_EMPHASIS_CTRL = 4'h2;
  localparam logic [3:0] OFS_IN_OFF = 4'h3;
  localparam logic [3:0] OFS_OUT_OFF = 4'h4;
  localparam logic [3:0] OFS_RESTART = 4'h5;
  localparam logic [3:0] OFS_PWR = 4'h6;
  localparam logic [3:0] OFS_LOAD_DETECT_ENABLE = 4'h7;
  localparam logic [3:0] OFS_EQ_A = 4'h8;
  localparam logic [3:0] OFS_EQ_B = 4'h9;
  localparam logic [3:0] OFS_RSVD = 4'ha;
  localparam logic [3:0] OFS_THRESH = 4'hb;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int LOOP_MSB = 7;
  localparam int LOOP_LSB = 4;
  localparam int DE_A_BIT = 3;
  localparam int DE_B_BIT = 2;
  localparam logic [7:0] LOOPBACK_EMPHASIS_CTRL_WMASK = 8'hfc;
  localparam logic [1:0] ADDR_TOP = 2'h3;
  localparam logic [1:0] ADDR_GAP = 2'h0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RESTART = 8'hff;
  localparam logic [7:0] RST_PWR = 8'hff;
  localparam logic [7:0] RST_LOAD_DETECT_ENABLE = 8'hff;
  localparam logic [7:0] RST_EQ = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'hef;
  localparam logic [1:0] RST_DEEMPH = 2'h0;
  // ----------------------------------------
  // Pin filter timing
  // ----------------------------------------
  localparam int GLITCH_NS = 50;
  localparam int LINK_PERIOD_NS = 32;
  localparam int FILT_CYC_RAW = (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
endpackage

// ---- lcis_sync2.sv ----
/*
  Two flip-flop synchroniser for a bus of independent levels.
  Assumes each bit is a level that stays put for several clock cycles.
*/
`timescale 1ns/1ps
module lcis_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
